// *** pwsm_pkg.sv ***
// package of constants and carriers for the power state machine
package pwsm_pkg;

  // sleep request field codes
  localparam logic [1:0] REQ_RUN   = 2'h0;
  localparam logic [1:0] REQ_IDLE  = 2'h1;
  localparam logic [1:0] REQ_SLEEP = 2'h2;
  localparam logic [1:0] REQ_RSVD  = 2'h3;

  // power state field codes
  localparam logic [2:0] ST_LOCK_WAIT = 3'h0;
  localparam logic [2:0] ST_RUN       = 3'h1;
  localparam logic [2:0] ST_IDLE_REQ  = 3'h2;
  localparam logic [2:0] ST_IDLE_ACK  = 3'h3;
  localparam logic [2:0] ST_SLEEP     = 3'h4;
  localparam logic [2:0] ST_DEEP      = 3'h5;

  // watchdog wake edge
  localparam logic [15:0] WDT_BEFORE = 16'h7FFF;
  localparam logic [15:0] WDT_AFTER  = 16'h8000;
  localparam int          WDT_MSB    = 15;

  // reset values and peripheral count
  localparam logic [1:0] RST_SLEEP_REQ = 2'h0;
  localparam logic       RST_DS_REQ    = 1'b0;
  localparam logic       RST_DS_RE     = 1'b0;
  localparam int         NUM_PERIPH    = 4;

  // wake cause codes
  typedef enum logic [1:0] {
    pwsm_cause_none_e,
    pwsm_cause_reset_e,
    pwsm_cause_wdt_e,
    pwsm_cause_irq_e
  } pwsm_cause_e;

  // wake event group
  typedef struct packed {
    logic irq;
    logic nmi_fall;
    logic wdt_nmi;
    logic hw_reset;
    logic sw_reset;
  } pwsm_wake_s;

  // clock and pin control group
  typedef struct packed {
    logic cpu_clk_en;
    logic mem_clk_en;
    logic pll_osc_en;
    logic pins_hold;
    logic inputs_disable;
    logic pins_to_reset;
    logic sys_reset;
  } pwsm_ctrl_s;

endpackage : pwsm_pkg

// *** pwsm_periph_gate.sv ***
// per-peripheral sleep response using its clock control bits
`timescale 1ns/100ps
module pwsm_periph_gate (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // control
  input  wire logic sleep_in,
  input  wire logic sleep_disable_bit_in,
  input  wire logic fast_shutoff_bit_in,
  input  wire logic bus_busy_in,
  input  wire logic op_busy_in,
  // result
  output logic      clk_en_out,
  output logic      abort_out
);
  typedef struct packed {
    logic clk_en;
    logic abort;
  } pwsm_pg_s;

  pwsm_pg_s st_ff, nxt_st;

  // decide clock gate each cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_st.abort = 1'b0;
    if (!sleep_in || sleep_disable_bit_in) begin
      nxt_st.clk_en = 1'b1;
    end else if (fast_shutoff_bit_in) begin
      nxt_st.abort  = st_ff.clk_en && op_busy_in;
      nxt_st.clk_en = bus_busy_in;
    end else begin
      nxt_st.clk_en = bus_busy_in || op_busy_in;
    end
  end

  // state register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '{clk_en: 1'b1, abort: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clk_en_out = st_ff.clk_en;
  assign abort_out  = st_ff.abort;
endmodule : pwsm_periph_gate

// *** pwsm_power_state_machine.sv ***
// power state machine: run, idle, sleep and deep sleep control
// Overview of operation
// - Writing 01 to the sleep request field requests idle mode.
// - Idle request goes to CPU; after acknowledge CPU and memory clocks stop.
// - Memory bus access during idle wakes memories until transaction ends.
// - Enabled irq, NMI, watchdog, hardware or software reset return to run.
// - Watchdog counter 7FFF to 8000 in idle raises an NMI trap request.
// - Wake cause chooses reset sequence, resume, or vector to handler.
// - Writing 10 to the sleep request field requests sleep mode.
// - Sleep broadcast only after the CPU idle acknowledge.
// - Peripheral with sleep disable set ignores the sleep broadcast.
// - Enabled peripheral finishes bus transaction, then suspends.
// - Fast shut-off aborts operations, clock stops when the bus is idle; else operations finish first.
// - Sleep ends on idle wake events; peripherals resume run operation.
// - Deep sleep requested by setting the separate deep sleep request bit.
// - Deep sleep register writable only while init end bit is clear.
// - Deep entry: CPU handshake, sleep broadcast, then clocks, PLL, osc off.
// - In deep sleep pins hold their values; DRAM is not refreshed.
// - Deep sleep ends only on power-on reset or NMI pin falling edge.
// - Power-on wake waits for PLL lock and power-on reset release.
// - Pin wake with reset enable set resets device and port pins.
// - Pin wake with reset enable clear resumes without PLL lock.
// - In deep sleep outputs hold; inputs disabled only if reset enable set.
// - Sleep request field cleared on irq, deep wake, or watchdog bit 15 rise.
// - Deep sleep request bit cleared by hardware on deep sleep wake.
// - Three-bit state field reports lock wait, run, idle, sleep, deep.
`timescale 1ns/100ps
module pwsm_power_state_machine #(
  parameter int NUM_PERIPH = pwsm_pkg::NUM_PERIPH
) (
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_b_in,
  // external pins, asynchronous
  input  wire logic                  power_on_reset_b_in,
  input  wire logic                  hardware_reset_b_in,
  input  wire logic                  nmi_b_in,
  // software writes
  input  wire logic                  sleep_req_wr_in,
  input  wire logic [1:0]            sleep_req_data_in,
  input  wire logic                  deep_ctrl_wr_in,
  input  wire logic                  deep_req_data_in,
  input  wire logic                  deep_reset_en_data_in,
  input  wire logic                  init_end_bit_in,
  input  wire logic                  sw_reset_req_in,
  // system events
  input  wire logic                  irq_enabled_in,
  input  wire logic [15:0]           watchdog_counter_in,
  input  wire logic                  pll_lock_flag_in,
  input  wire logic                  pll_clock_ok_in,
  // cpu handshake
  input  wire logic                  cpu_idle_ack_in,
  input  wire logic                  mem_access_in,
  // peripherals
  input  wire logic [NUM_PERIPH-1:0] sleep_disable_bit_in,
  input  wire logic [NUM_PERIPH-1:0] fast_shutoff_bit_in,
  input  wire logic [NUM_PERIPH-1:0] periph_bus_busy_in,
  input  wire logic [NUM_PERIPH-1:0] periph_op_busy_in,
  // status
  output logic [1:0]                 sleep_request_field_out,
  output logic                       deep_sleep_request_bit_out,
  output logic                       deep_sleep_reset_enable_bit_out,
  output logic [2:0]                 power_state_field_out,
  // control outputs
  output logic                       cpu_idle_req_out,
  output logic                       sleep_broadcast_out,
  output logic                       wdt_nmi_req_out,
  output pwsm_pkg::pwsm_cause_e      wake_cause_out,
  output pwsm_pkg::pwsm_ctrl_s       ctrl_out,
  output logic [NUM_PERIPH-1:0]      periph_clk_en_out,
  output logic [NUM_PERIPH-1:0]      periph_abort_out
);
  initial begin
    if (NUM_PERIPH < 1) begin
      $error("NUM_PERIPH must be at least one");
    end
  end

  typedef enum logic [2:0] {
    pwsm_lock_wait_e,
    pwsm_run_e,
    pwsm_idle_req_e,
    pwsm_idle_ack_e,
    pwsm_sleep_e,
    pwsm_deep_e
  } pwsm_state_e;

  typedef struct packed {
    pwsm_state_e           state;
    logic [1:0]            sleep_req;
    logic                  ds_req;
    logic                  ds_re;
    logic                  ds_pending;
    logic                  wr_seen;
    logic                  sleep_goal;
    logic [2:0]            pin_s1;
    logic [2:0]            pin_s2;
    logic                  nmi_d;
    logic                  wdt_msb_d;
    logic [15:0]           wdt_d;
    logic                  wdt_nmi;
    logic                  bcast;
    logic                  idle_req;
    pwsm_pkg::pwsm_cause_e cause;
    pwsm_pkg::pwsm_ctrl_s  ctrl;
    logic [2:0]            st_code;
  } pwsm_all_s;

  pwsm_all_s  st_ff, nxt_st;
  pwsm_pkg::pwsm_wake_s wake;
  logic       por_b_s, hdr_b_s, nmi_b_s;

  // map a state to its reported code
  function automatic logic [2:0] state_code(input pwsm_state_e s);
    unique case (s)
      pwsm_lock_wait_e: state_code = pwsm_pkg::ST_LOCK_WAIT;
      pwsm_run_e:       state_code = pwsm_pkg::ST_RUN;
      pwsm_idle_req_e:  state_code = pwsm_pkg::ST_IDLE_REQ;
      pwsm_idle_ack_e:  state_code = pwsm_pkg::ST_IDLE_ACK;
      pwsm_sleep_e:     state_code = pwsm_pkg::ST_SLEEP;
      pwsm_deep_e:      state_code = pwsm_pkg::ST_DEEP;
      default:          state_code = pwsm_pkg::ST_LOCK_WAIT;
    endcase
  endfunction : state_code

  // synchronised pin levels, read only from the second stage
  assign por_b_s = st_ff.pin_s2[0];
  assign hdr_b_s = st_ff.pin_s2[1];
  assign nmi_b_s = st_ff.pin_s2[2];

  // wake events gathered
  always_comb begin
    wake.irq      = irq_enabled_in;
    wake.nmi_fall = st_ff.nmi_d && !nmi_b_s;
    wake.wdt_nmi  = st_ff.wdt_nmi;
    wake.hw_reset = !hdr_b_s;
    wake.sw_reset = sw_reset_req_in;
  end

  // next state
  always_comb begin
    logic any_wake;
    logic wdt_edge;
    logic msb_rise;
    any_wake = 1'b0;
    wdt_edge = 1'b0;
    msb_rise = 1'b0;
    nxt_st = st_ff;
    nxt_st.pin_s1 = {nmi_b_in, hardware_reset_b_in, power_on_reset_b_in};
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.nmi_d = nmi_b_s;
    nxt_st.wdt_d = watchdog_counter_in;
    nxt_st.wdt_msb_d = watchdog_counter_in[pwsm_pkg::WDT_MSB];
    nxt_st.wdt_nmi = 1'b0;
    wdt_edge = (st_ff.wdt_d == pwsm_pkg::WDT_BEFORE)
            && (watchdog_counter_in == pwsm_pkg::WDT_AFTER);
    msb_rise = !st_ff.wdt_msb_d
            && watchdog_counter_in[pwsm_pkg::WDT_MSB];
    if (wdt_edge && st_ff.state != pwsm_run_e
        && st_ff.state != pwsm_deep_e) begin
      nxt_st.wdt_nmi = 1'b1;
    end
    any_wake = wake.irq || wake.nmi_fall || wake.wdt_nmi
            || wake.hw_reset || wake.sw_reset;

    // software writes; hardware clears below win over them
    if (sleep_req_wr_in) begin
      nxt_st.sleep_req = sleep_req_data_in;
    end
    if (deep_ctrl_wr_in && !init_end_bit_in) begin
      nxt_st.ds_pending = deep_req_data_in;
      nxt_st.ds_re      = deep_reset_en_data_in;
      nxt_st.wr_seen    = 1'b1;
    end
    if (st_ff.wr_seen && init_end_bit_in) begin
      nxt_st.ds_req  = st_ff.ds_pending;
      nxt_st.wr_seen = 1'b0;
    end
    if (st_ff.state inside {pwsm_idle_req_e, pwsm_idle_ack_e,
        pwsm_sleep_e} && (wake.irq || msb_rise)) begin
      nxt_st.sleep_req = pwsm_pkg::REQ_RUN;
    end

    nxt_st.cause = pwsm_pkg::pwsm_cause_none_e;
    nxt_st.ctrl.sys_reset = 1'b0;

    unique case (st_ff.state)
      pwsm_lock_wait_e: begin
        nxt_st.ctrl = '{cpu_clk_en: 1'b0, mem_clk_en: 1'b0,
                        pll_osc_en: 1'b1, pins_hold: 1'b0,
                        inputs_disable: 1'b0, pins_to_reset: 1'b1,
                        sys_reset: 1'b1};
        if (pll_lock_flag_in && por_b_s) begin
          nxt_st.state = pwsm_run_e;
          nxt_st.ctrl.cpu_clk_en = 1'b1;
          nxt_st.ctrl.mem_clk_en = 1'b1;
          nxt_st.ctrl.pins_to_reset = 1'b0;
          nxt_st.ctrl.sys_reset = 1'b0;
        end
      end
      pwsm_run_e: begin
        nxt_st.ctrl.cpu_clk_en = 1'b1;
        nxt_st.ctrl.mem_clk_en = 1'b1;
        nxt_st.bcast = 1'b0;
        if (st_ff.ds_req) begin
          nxt_st.state = pwsm_idle_req_e;
          nxt_st.sleep_goal = 1'b1;
        end else if (st_ff.sleep_req == pwsm_pkg::REQ_IDLE
                  || st_ff.sleep_req == pwsm_pkg::REQ_SLEEP) begin
          nxt_st.state = pwsm_idle_req_e;
          nxt_st.sleep_goal = st_ff.sleep_req == pwsm_pkg::REQ_SLEEP;
        end
      end
      pwsm_idle_req_e: begin
        if (any_wake) begin
          nxt_st.state = pwsm_run_e;
        end else if (cpu_idle_ack_in) begin
          nxt_st.ctrl.cpu_clk_en = 1'b0;
          nxt_st.ctrl.mem_clk_en = mem_access_in;
          nxt_st.state = st_ff.sleep_goal ? pwsm_sleep_e
                                          : pwsm_idle_ack_e;
          nxt_st.bcast = st_ff.sleep_goal;
        end
      end
      pwsm_idle_ack_e, pwsm_sleep_e: begin
        nxt_st.ctrl.mem_clk_en = mem_access_in;
        if (any_wake) begin
          nxt_st.state = pwsm_run_e;
          nxt_st.bcast = 1'b0;
          nxt_st.ctrl.cpu_clk_en = 1'b1;
          nxt_st.ctrl.mem_clk_en = 1'b1;
          nxt_st.sleep_req = pwsm_pkg::REQ_RUN;
        end else if (st_ff.state == pwsm_sleep_e && st_ff.ds_req) begin
          nxt_st.state = pwsm_deep_e;
          nxt_st.ctrl.mem_clk_en = 1'b0;
          nxt_st.ctrl.pll_osc_en = 1'b0;
          nxt_st.ctrl.pins_hold = 1'b1;
          nxt_st.ctrl.inputs_disable = st_ff.ds_re;
        end
      end
      pwsm_deep_e: begin
        if (!por_b_s || wake.nmi_fall) begin
          nxt_st.ds_req = 1'b0;
          nxt_st.sleep_req = pwsm_pkg::REQ_RUN;
          nxt_st.bcast = 1'b0;
          nxt_st.ctrl.pll_osc_en = 1'b1;
          if (!por_b_s || st_ff.ds_re) begin
            nxt_st.state = pwsm_lock_wait_e;
            nxt_st.ctrl.pins_hold = 1'b0;
            nxt_st.ctrl.inputs_disable = 1'b0;
            nxt_st.ctrl.pins_to_reset = 1'b1;
            nxt_st.ctrl.sys_reset = 1'b1;
          end else begin
            nxt_st.state = pwsm_run_e;
            nxt_st.ctrl.cpu_clk_en = 1'b1;
            nxt_st.ctrl.mem_clk_en = 1'b1;
            nxt_st.ctrl.inputs_disable = 1'b0;
            nxt_st.cause = pwsm_pkg::pwsm_cause_irq_e;
          end
        end
      end
    endcase

    // pins hold after fast wake until software releases them
    if (st_ff.state == pwsm_run_e && sleep_req_wr_in) begin
      nxt_st.ctrl.pins_hold = 1'b0;
    end

    // wake cause tells the CPU how to resume
    if (st_ff.state inside {pwsm_idle_req_e, pwsm_idle_ack_e,
        pwsm_sleep_e} && any_wake) begin
      if (wake.hw_reset || wake.sw_reset) begin
        nxt_st.cause = pwsm_pkg::pwsm_cause_reset_e;
        nxt_st.ctrl.sys_reset = 1'b1;
      end else if (wake.irq || wake.nmi_fall) begin
        nxt_st.cause = pwsm_pkg::pwsm_cause_irq_e;
      end else begin
        nxt_st.cause = pwsm_pkg::pwsm_cause_wdt_e;
      end
    end
    nxt_st.st_code = state_code(nxt_st.state);
    nxt_st.idle_req = nxt_st.state == pwsm_idle_req_e;
  end

  // state register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '{state: pwsm_lock_wait_e,
                 sleep_req: pwsm_pkg::RST_SLEEP_REQ,
                 ds_req: pwsm_pkg::RST_DS_REQ,
                 ds_re: pwsm_pkg::RST_DS_RE,
                 ctrl: '{pll_osc_en: 1'b1, pins_to_reset: 1'b1,
                         sys_reset: 1'b1, default: 1'b0},
                 pin_s1: 3'h0, pin_s2: 3'h0,
                 st_code: pwsm_pkg::ST_LOCK_WAIT,
                 cause: pwsm_pkg::pwsm_cause_none_e,
                 wdt_d: 16'h0000,
                 default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // per-peripheral sleep responses
  for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
    pwsm_periph_gate u_gate (
      .clock_in             (clock_in),
      .rst_b_in             (rst_b_in),
      .sleep_in             (st_ff.bcast),
      .sleep_disable_bit_in (sleep_disable_bit_in[i]),
      .fast_shutoff_bit_in  (fast_shutoff_bit_in[i]),
      .bus_busy_in          (periph_bus_busy_in[i]),
      .op_busy_in           (periph_op_busy_in[i]),
      .clk_en_out           (periph_clk_en_out[i]),
      .abort_out            (periph_abort_out[i])
    );
  end

  // outputs from registers
  assign sleep_request_field_out         = st_ff.sleep_req;
  assign deep_sleep_request_bit_out      = st_ff.ds_req;
  assign deep_sleep_reset_enable_bit_out = st_ff.ds_re;
  assign power_state_field_out           = st_ff.st_code;
  assign cpu_idle_req_out                = st_ff.idle_req;
  assign sleep_broadcast_out             = st_ff.bcast;
  assign wdt_nmi_req_out                 = st_ff.wdt_nmi;
  assign wake_cause_out                  = st_ff.cause;
  assign ctrl_out                        = st_ff.ctrl;
endmodule : pwsm_power_state_machine

// *** pwsm_assertions.sv ***
// concurrent checks on the power state machine ports
`timescale 1ns/100ps
module pwsm_assertions #(
  parameter int NUM_PERIPH = 4
) (
  // clock and reset
  input wire logic                  clock_in,
  input wire logic                  rst_b_in,
  // watched inputs
  input wire logic                  irq_enabled_in,
  input wire logic [15:0]           watchdog_counter_in,
  input wire logic                  cpu_idle_ack_in,
  input wire logic [NUM_PERIPH-1:0] sleep_disable_bit_in,
  input wire logic [NUM_PERIPH-1:0] fast_shutoff_bit_in,
  // watched outputs
  input wire logic [1:0]            sleep_request_field_out,
  input wire logic                  deep_sleep_request_bit_out,
  input wire logic                  deep_sleep_reset_enable_bit_out,
  input wire logic [2:0]            power_state_field_out,
  input wire logic                  cpu_idle_req_out,
  input wire logic                  sleep_broadcast_out,
  input wire logic                  wdt_nmi_req_out,
  input wire pwsm_pkg::pwsm_cause_e wake_cause_out,
  input wire pwsm_pkg::pwsm_ctrl_s  ctrl_out,
  input wire logic [NUM_PERIPH-1:0] periph_clk_en_out
);
  // short names for the state field and the idle and sleep states
  wire [2:0] st     = power_state_field_out;
  wire       dozing = st == pwsm_pkg::ST_IDLE_ACK || st == pwsm_pkg::ST_SLEEP;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  // steps of the mode changes
  sequence s_ack_taken;
    $past(st) == pwsm_pkg::ST_IDLE_REQ && $past(cpu_idle_ack_in);
  endsequence
  sequence s_deep_left;
    st == pwsm_pkg::ST_DEEP ##1 st != pwsm_pkg::ST_DEEP;
  endsequence
  sequence s_wdt_edge;
    dozing && watchdog_counter_in == pwsm_pkg::WDT_AFTER
      && $past(watchdog_counter_in) == pwsm_pkg::WDT_BEFORE;
  endsequence

  chk_idle_entry:
    assert property (st == pwsm_pkg::ST_RUN && !deep_sleep_request_bit_out
      && sleep_request_field_out == pwsm_pkg::REQ_IDLE
      |=> st == pwsm_pkg::ST_IDLE_REQ) else $error("idle entry missed");
  chk_req_level:
    assert property (cpu_idle_req_out == (st == pwsm_pkg::ST_IDLE_REQ))
      else $error("idle request level wrong");
  chk_idle_gate:
    assert property (st == pwsm_pkg::ST_IDLE_REQ ##1 st == pwsm_pkg::ST_IDLE_ACK
      |-> $past(cpu_idle_ack_in) && !ctrl_out.cpu_clk_en)
      else $error("idle acknowledged wrongly");
  chk_bcast_after_ack:
    assert property ($rose(sleep_broadcast_out) |-> s_ack_taken)
      else $error("broadcast before acknowledge");
  chk_rsvd_code:
    assert property (st == pwsm_pkg::ST_RUN && !deep_sleep_request_bit_out
      && sleep_request_field_out == pwsm_pkg::REQ_RSVD
      |=> st == pwsm_pkg::ST_RUN) else $error("reserved code left run");
  chk_wdt_trap:
    assert property (s_wdt_edge |-> ##[0:2] wdt_nmi_req_out)
      else $error("watchdog trap missing");
  chk_irq_wake:
    assert property (dozing && irq_enabled_in |-> ##[1:3] st == pwsm_pkg::ST_RUN
      && wake_cause_out == pwsm_pkg::pwsm_cause_irq_e)
      else $error("interrupt wake missing");
  chk_deep_outputs:
    assert property (st == pwsm_pkg::ST_DEEP |-> !ctrl_out.pll_osc_en
      && !ctrl_out.cpu_clk_en && ctrl_out.pins_hold
      && ctrl_out.inputs_disable == deep_sleep_reset_enable_bit_out)
      else $error("deep sleep outputs wrong");
  chk_deep_clear:
    assert property (s_deep_left |-> ##[0:1] !deep_sleep_request_bit_out
      && sleep_request_field_out == pwsm_pkg::REQ_RUN)
      else $error("requests not cleared on deep wake");
  chk_sleep_disable:
    assert property ($stable(sleep_disable_bit_in) [*3]
      |-> &(periph_clk_en_out | ~sleep_disable_bit_in))
      else $error("sleep disabled unit stopped");
  chk_fast_stop:
    assert property ($rose(sleep_broadcast_out) |-> ##[0:2]
      &(~periph_clk_en_out | sleep_disable_bit_in | ~fast_shutoff_bit_in))
      else $error("fast shut-off unit still clocked");
endmodule : pwsm_assertions

// *** pwsm_cpu_model.sv ***
// cpu core stand-in answering the idle request after a set delay
`timescale 1ns/100ps
module pwsm_cpu_model (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  // handshake
  input  wire logic       idle_req_in,
  input  wire logic       awake_in,
  input  wire logic [3:0] delay_in,
  output logic            idle_ack_out
);
  logic [3:0] cnt_ff;

  // finish current work for delay_in+1 cycles, then hold ack until run
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff       <= 4'h0;
      idle_ack_out <= 1'b0;
    end else if (awake_in && !idle_req_in) begin
      cnt_ff       <= 4'h0;
      idle_ack_out <= 1'b0;
    end else if (idle_req_in && !idle_ack_out) begin
      cnt_ff       <= cnt_ff + 4'h1;
      idle_ack_out <= cnt_ff >= delay_in;
    end
  end
endmodule : pwsm_cpu_model

// *** pwsm_power_state_machine_bench.sv ***
// self-checking bench for the power state machine
`timescale 1ns/100ps
module pwsm_power_state_machine_bench;
  localparam int NP = 4;
  // stimulus
  logic clock_in = 1'b0, rst_b_in = 1'b0, power_on_reset_b_in = 1'b0;
  logic hardware_reset_b_in = 1'b1, nmi_b_in = 1'b1, sw_reset_req_in = 1'b0;
  logic sleep_req_wr_in = 1'b0, deep_ctrl_wr_in = 1'b0, mem_access_in = 1'b0;
  logic deep_req_data_in = 1'b0, deep_reset_en_data_in = 1'b0;
  logic init_end_bit_in = 1'b1, irq_enabled_in = 1'b0, pll_clock_ok_in = 1'b1;
  logic pll_lock_flag_in = 1'b0, cpu_idle_ack_in;
  logic [1:0]    sleep_req_data_in = 2'h0;
  logic [15:0]   watchdog_counter_in = 16'h0000;
  logic [NP-1:0] sleep_disable_bit_in = 4'h3, fast_shutoff_bit_in = 4'h5;
  logic [NP-1:0] periph_bus_busy_in = 4'h0, periph_op_busy_in = 4'h0;
  logic [3:0]    ack_delay = 4'h3;
  // observed
  logic [1:0]    sleep_request_field_out;
  logic [2:0]    power_state_field_out;
  logic          deep_sleep_request_bit_out, deep_sleep_reset_enable_bit_out;
  logic          cpu_idle_req_out, sleep_broadcast_out, wdt_nmi_req_out;
  logic [NP-1:0] periph_clk_en_out, periph_abort_out;
  pwsm_pkg::pwsm_cause_e wake_cause_out, cause;
  pwsm_pkg::pwsm_ctrl_s  ctrl_out;
  int error_cnt = 0;
  int total_checks = 0;

  // clock at 125 MHz
  always #4 clock_in = ~clock_in;

  pwsm_power_state_machine #(.NUM_PERIPH(NP)) pwsm_power_state_machine_i (.*);
  pwsm_cpu_model pwsm_cpu_model_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .idle_req_in(cpu_idle_req_out), .delay_in(ack_delay),
    .awake_in(power_state_field_out <= pwsm_pkg::ST_RUN),
    .idle_ack_out(cpu_idle_ack_in));

  // compare and count
  task automatic chk(input string nm, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic results;
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic tk(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tk

  // bounded wait for a state, keeps the wake cause seen on arrival
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (power_state_field_out !== s && n < 60) begin
      tk(1);
      n++;
    end
    cause = wake_cause_out;
    if (n == 60) begin
      error_cnt++;
      $display("Error state expected %h seen %h", s, power_state_field_out);
      results;
    end
  endtask : wait_st

  task automatic wr_req(input logic [1:0] d);
    @(posedge clock_in);
    sleep_req_wr_in   <= 1'b1;
    sleep_req_data_in <= d;
    tk(1);
    sleep_req_wr_in <= 1'b0;
  endtask : wr_req

  task automatic pulse_irq;
    @(posedge clock_in);
    irq_enabled_in <= 1'b1;
    tk(1);
    irq_enabled_in <= 1'b0;
  endtask : pulse_irq

  task automatic wr_deep(input logic rq, input logic re);
    @(posedge clock_in);
    deep_ctrl_wr_in       <= 1'b1;
    deep_req_data_in      <= rq;
    deep_reset_en_data_in <= re;
    tk(1);
    deep_ctrl_wr_in <= 1'b0;
  endtask : wr_deep

  // idle entry, memory access while idle, interrupt wake
  task automatic t_idle;
    wr_req(pwsm_pkg::REQ_IDLE);
    chk("req field", sleep_request_field_out, pwsm_pkg::REQ_IDLE);
    wait_st(pwsm_pkg::ST_IDLE_ACK);
    chk("cpu clock", ctrl_out.cpu_clk_en, 1'b0);
    chk("mem clock", ctrl_out.mem_clk_en, 1'b0);
    @(posedge clock_in);
    mem_access_in <= 1'b1;
    tk(3);
    chk("mem wake", ctrl_out.mem_clk_en, 1'b1);
    mem_access_in <= 1'b0;
    tk(3);
    chk("mem back", ctrl_out.mem_clk_en, 1'b0);
    chk("still idle", power_state_field_out, pwsm_pkg::ST_IDLE_ACK);
    pulse_irq();
    wait_st(pwsm_pkg::ST_RUN);
    chk("irq cause", cause, pwsm_pkg::pwsm_cause_irq_e);
    chk("field clr", sleep_request_field_out, pwsm_pkg::REQ_RUN);
  endtask : t_idle

  // sleep with per unit response, watchdog wake, then reserved code
  task automatic t_sleep;
    ack_delay <= 4'h0;
    periph_op_busy_in <= 4'hC;
    watchdog_counter_in <= 16'h7FFE;
    wr_req(pwsm_pkg::REQ_SLEEP);
    wait_st(pwsm_pkg::ST_SLEEP);
    chk("broadcast", sleep_broadcast_out, 1'b1);
    tk(1);
    chk("abort", periph_abort_out, 4'h4);
    chk("op finish", periph_clk_en_out, 4'hB);
    periph_op_busy_in <= 4'h0;
    tk(2);
    chk("unit clocks", periph_clk_en_out, 4'h3);
    watchdog_counter_in <= 16'h7FFF;
    @(posedge clock_in);
    watchdog_counter_in <= 16'h8000;
    wait_st(pwsm_pkg::ST_RUN);
    chk("wdt cause", cause, pwsm_pkg::pwsm_cause_wdt_e);
    chk("field clr", sleep_request_field_out, pwsm_pkg::REQ_RUN);
    tk(3);
    chk("units run", periph_clk_en_out, 4'hF);
    wr_req(pwsm_pkg::REQ_RSVD);
    tk(4);
    chk("rsvd state", power_state_field_out, pwsm_pkg::ST_RUN);
    wr_req(pwsm_pkg::REQ_RUN);
  endtask : t_sleep

  // guarded deep request, entry, immunity to internal events
  task automatic deep_in(input logic re);
    wr_deep(1'b1, re);
    tk(2);
    chk("locked write", deep_sleep_request_bit_out, 1'b0);
    init_end_bit_in <= 1'b0;
    wr_deep(1'b1, re);
    tk(3);
    chk("not yet", power_state_field_out, pwsm_pkg::ST_RUN);
    chk("reset en", deep_sleep_reset_enable_bit_out, re);
    init_end_bit_in <= 1'b1;
    wait_st(pwsm_pkg::ST_DEEP);
    chk("pins hold", ctrl_out.pins_hold, 1'b1);
    chk("inputs off", ctrl_out.inputs_disable, re);
    pll_lock_flag_in <= 1'b0;
    watchdog_counter_in <= 16'h7FFF;
    pulse_irq();
    watchdog_counter_in <= 16'h8000;
    tk(5);
    chk("stay deep", power_state_field_out, pwsm_pkg::ST_DEEP);
  endtask : deep_in

  // pin wake, without and with reset, then power-on wake
  task automatic t_deep;
    deep_in(1'b0);
    nmi_b_in <= 1'b0;
    wait_st(pwsm_pkg::ST_RUN);
    chk("fast wake hold", ctrl_out.pins_hold, 1'b1);
    chk("ds bit clr", deep_sleep_request_bit_out, 1'b0);
    nmi_b_in <= 1'b1;
    pll_lock_flag_in <= 1'b1;
    wr_req(pwsm_pkg::REQ_RUN);
    chk("hold freed", ctrl_out.pins_hold, 1'b0);
    deep_in(1'b1);
    nmi_b_in <= 1'b0;
    wait_st(pwsm_pkg::ST_LOCK_WAIT);
    chk("pins reset", ctrl_out.pins_to_reset, 1'b1);
    pll_lock_flag_in <= 1'b1;
    wait_st(pwsm_pkg::ST_RUN);
    nmi_b_in <= 1'b1;
    deep_in(1'b0);
    power_on_reset_b_in <= 1'b0;
    tk(4);
    power_on_reset_b_in <= 1'b1;
    wait_st(pwsm_pkg::ST_LOCK_WAIT);
    tk(4);
    chk("lock wait", power_state_field_out, pwsm_pkg::ST_LOCK_WAIT);
    pll_lock_flag_in <= 1'b1;
    wait_st(pwsm_pkg::ST_RUN);
    chk("ds bit clr", deep_sleep_request_bit_out, 1'b0);
  endtask : t_deep

  // main sequence
  initial begin
    tk(6);
    chk("reset state", power_state_field_out, pwsm_pkg::ST_LOCK_WAIT);
    rst_b_in <= 1'b1;
    power_on_reset_b_in <= 1'b1;
    pll_lock_flag_in <= 1'b1;
    wait_st(pwsm_pkg::ST_RUN);
    chk("boot ds bit", deep_sleep_request_bit_out, 1'b0);
    t_idle();
    t_sleep();
    t_deep();
    results();
  end
endmodule : pwsm_power_state_machine_bench

bind pwsm_power_state_machine pwsm_assertions #(.NUM_PERIPH(NUM_PERIPH))
  pwsm_assertions_i (.*);
